//--- pin_select_defines.svh
// Offsets, field layouts, masks and reset values of the remappable pin select block.
`ifndef PIN_SELECT_DEFINES_SVH
`define PIN_SELECT_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_UART4_INPUT_SELECT 12'h000
`define OFS_SPI3_CLOCK_DATA_INPUT_SELECT 12'h004
`define OFS_SPI3_SLAVE_SELECT_INPUT_SELECT 12'h008
`define OFS_PIN0_PIN1_OUTPUT_SELECT 12'h00c
`define OFS_PIN2_PIN3_OUTPUT_SELECT 12'h010
`define OFS_PIN4_PIN5_OUTPUT_SELECT 12'h014

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_UART4_IN 3'h0
`define IDX_SPI3_CD_IN 3'h1
`define IDX_SPI3_SS_IN 3'h2
`define IDX_PIN01_OUT 3'h3
`define IDX_PIN23_OUT 3'h4
`define IDX_PIN45_OUT 3'h5
`define NUM_REGS 6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SEL_LO_LSB 0
`define SEL_HI_LSB 8
`define SEL_W 6

// ----------------------------------------
// Implemented bits and reset values
// ----------------------------------------
`define MASK_TWO_FIELDS 16'h3f3f
`define MASK_LOW_FIELD 16'h003f
`define MASK_NONE 16'h0000
`define RESET_INPUT_SEL 16'h3f3f
`define RESET_INPUT_SS 16'h003f
`define RESET_OUTPUT_SEL 16'h0000
`define OUT_FUNC_NONE 6'h00

`endif

//--- pin_select_pkg.sv
// Types shared by the remappable pin select block.
package pin_select_pkg;
  typedef logic [5:0] sel_t;
  typedef logic [2:0] reg_idx_t;
  typedef logic [15:0] cfg_word_t;
endpackage : pin_select_pkg

//--- route_sel_if.sv
// Selector values passed from the register file to the routing mux.
`timescale 1ns/1ps
interface route_sel_if;
  pin_select_pkg::sel_t uart4_rx_pin_sel;
  pin_select_pkg::sel_t uart4_cts_pin_sel;
  pin_select_pkg::sel_t spi3_clk_pin_sel;
  pin_select_pkg::sel_t spi3_din_pin_sel;
  pin_select_pkg::sel_t spi3_ss_pin_sel;
  pin_select_pkg::sel_t out_func_sel [6];
  modport regs (output uart4_rx_pin_sel, uart4_cts_pin_sel, spi3_clk_pin_sel, spi3_din_pin_sel,
    spi3_ss_pin_sel, out_func_sel);
  modport mux (input uart4_rx_pin_sel, uart4_cts_pin_sel, spi3_clk_pin_sel, spi3_din_pin_sel,
    spi3_ss_pin_sel, out_func_sel);
endinterface : route_sel_if

//--- pin_route_mux.sv
// Combinational routing between remappable pins and peripheral signals.
`timescale 1ns/1ps
`include "pin_select_defines.svh"
module pin_route_mux (
  // Selectors
  route_sel_if.mux sel,
  // Pin and peripheral sides
  input wire logic [63:0] pin_level,
  input wire logic [63:0] func_level,
  output logic uart4_rx,
  output logic uart4_cts,
  output logic spi3_clk,
  output logic spi3_din,
  output logic spi3_ss,
  output logic [5:0] pin_out,
  output logic [5:0] pin_out_en
);

  function automatic logic pick(input logic [63:0] vec, input pin_select_pkg::sel_t idx);
    pick = vec[idx];
  endfunction : pick

  // ----------------------------------------
  // Input routing
  // ----------------------------------------
  // pin to input
  assign uart4_rx = pick(pin_level, sel.uart4_rx_pin_sel);
  assign uart4_cts = pick(pin_level, sel.uart4_cts_pin_sel);
  assign spi3_clk = pick(pin_level, sel.spi3_clk_pin_sel);
  assign spi3_din = pick(pin_level, sel.spi3_din_pin_sel);
  assign spi3_ss = pick(pin_level, sel.spi3_ss_pin_sel);

  // ----------------------------------------
  // Output routing
  // ----------------------------------------
  // Function zero means no peripheral, so the pin is released to its port logic.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_out_en[i] = (sel.out_func_sel[i] != `OUT_FUNC_NONE);
      pin_out[i] = pin_out_en[i] & pick(func_level, sel.out_func_sel[i]);
    end
  end

endmodule : pin_route_mux

//--- remappable_pin_select.sv
// APB register file and top level of the remappable pin select block.
`timescale 1ns/1ps
`include "pin_select_defines.svh"

// What this block does
// - Six-bit input selector names source pin
// - Input selectors reset to all ones
// - Unimplemented bits read back as zero
// - Slave-select selector uses only bits 5:0
// - Output selector n routes function n
// - Output selectors reset to zero
// - Even pin low field, odd high
// - Small package lacks pin 5 selector
// - UART clear-to-send selector in bits 13:8
// - SPI clock high, data low field
module remappable_pin_select #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Remappable pins
  input wire logic [63:0] pin_level,
  output logic [5:0] pin_out,
  output logic [5:0] pin_out_en,
  // Peripheral output functions, one level per function number
  input wire logic [63:0] func_level,
  // Peripheral inputs
  output logic uart4_rx,
  output logic uart4_cts,
  output logic spi3_clk,
  output logic spi3_din,
  output logic spi3_ss
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic decode(input logic [11:0] addr, output pin_select_pkg::reg_idx_t idx);
    decode = 1'b1;
    idx = `IDX_UART4_IN;
    if (addr == `OFS_UART4_INPUT_SELECT) begin
      idx = `IDX_UART4_IN;
    end else if (addr == `OFS_SPI3_CLOCK_DATA_INPUT_SELECT) begin
      idx = `IDX_SPI3_CD_IN;
    end else if (addr == `OFS_SPI3_SLAVE_SELECT_INPUT_SELECT) begin
      idx = `IDX_SPI3_SS_IN;
    end else if (addr == `OFS_PIN0_PIN1_OUTPUT_SELECT) begin
      idx = `IDX_PIN01_OUT;
    end else if (addr == `OFS_PIN2_PIN3_OUTPUT_SELECT) begin
      idx = `IDX_PIN23_OUT;
    end else if (addr == `OFS_PIN4_PIN5_OUTPUT_SELECT) begin
      idx = `IDX_PIN45_OUT;
    end else begin
      decode = 1'b0;
    end
  endfunction : decode

  // Only implemented bits are writable; everything else holds zero and so reads zero.
  function automatic pin_select_pkg::cfg_word_t impl_mask(input pin_select_pkg::reg_idx_t idx);
    if (idx == `IDX_SPI3_SS_IN) begin
      impl_mask = `MASK_LOW_FIELD;
    end else if (idx == `IDX_PIN45_OUT && SMALL_PACKAGE) begin
      impl_mask = `MASK_LOW_FIELD;
    end else if (idx > `IDX_PIN45_OUT) begin
      impl_mask = `MASK_NONE;
    end else begin
      impl_mask = `MASK_TWO_FIELDS;
    end
  endfunction : impl_mask

  function automatic pin_select_pkg::cfg_word_t reset_word(input pin_select_pkg::reg_idx_t idx);
    if (idx == `IDX_SPI3_SS_IN) begin
      reset_word = `RESET_INPUT_SS;
    end else if (idx < `IDX_SPI3_SS_IN) begin
      reset_word = `RESET_INPUT_SEL;
    end else begin
      reset_word = `RESET_OUTPUT_SEL;
    end
  endfunction : reset_word

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  pin_select_pkg::cfg_word_t cfg_r [`NUM_REGS];
  pin_select_pkg::reg_idx_t acc_idx;
  logic acc_hit;
  logic wr_fire;
  logic setup_rd;
  pin_select_pkg::cfg_word_t wr_bits;
  pin_select_pkg::cfg_word_t lane_mask;

  always_comb begin
    acc_hit = decode(paddr, acc_idx);
  end

  // Zero wait states: every access completes in its first access cycle.
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~acc_hit;
  assign wr_fire = psel & penable & pwrite & acc_hit;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wr_bits = pwdata[15:0];

  // ----------------------------------------
  // Mapping registers
  // ----------------------------------------
  // The mask keeps reserved bits at zero, and the pin 5 field at zero on the small package.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r[0] <= `RESET_INPUT_SEL;
      cfg_r[1] <= `RESET_INPUT_SEL;
      cfg_r[2] <= `RESET_INPUT_SS;
      cfg_r[3] <= `RESET_OUTPUT_SEL;
      cfg_r[4] <= `RESET_OUTPUT_SEL;
      cfg_r[5] <= `RESET_OUTPUT_SEL;
    end else if (wr_fire) begin
      cfg_r[acc_idx] <= ((cfg_r[acc_idx] & ~lane_mask) | (wr_bits & lane_mask)) & impl_mask(acc_idx);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Read data is captured in the setup cycle so that it stands as a flop in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd && acc_hit) begin
      prdata <= {16'h0000, cfg_r[acc_idx] & impl_mask(acc_idx)};
    end else if (setup_rd) begin
      prdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  route_sel_if sel_bus ();

  assign sel_bus.uart4_cts_pin_sel = cfg_r[0][`SEL_HI_LSB +: `SEL_W];
  assign sel_bus.uart4_rx_pin_sel = cfg_r[0][`SEL_LO_LSB +: `SEL_W];
  assign sel_bus.spi3_clk_pin_sel = cfg_r[1][`SEL_HI_LSB +: `SEL_W];
  assign sel_bus.spi3_din_pin_sel = cfg_r[1][`SEL_LO_LSB +: `SEL_W];
  assign sel_bus.spi3_ss_pin_sel = cfg_r[2][`SEL_LO_LSB +: `SEL_W];

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      sel_bus.out_func_sel[2 * p] = cfg_r[3 + p][`SEL_LO_LSB +: `SEL_W];
      sel_bus.out_func_sel[2 * p + 1] = cfg_r[3 + p][`SEL_HI_LSB +: `SEL_W];
    end
  end

  // ----------------------------------------
  // Routing
  // ----------------------------------------
  // routing follows registers
  pin_route_mux u_mux (
    .sel(sel_bus.mux),
    .pin_level(pin_level),
    .func_level(func_level),
    .uart4_rx(uart4_rx),
    .uart4_cts(uart4_cts),
    .spi3_clk(spi3_clk),
    .spi3_din(spi3_din),
    .spi3_ss(spi3_ss),
    .pin_out(pin_out),
    .pin_out_en(pin_out_en)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_rx_route;
    @(posedge pclk) disable iff (!presetn)
    uart4_rx == pin_level[cfg_r[0][5:0]];
  endproperty
  a_rx_route: assert property (p_rx_route) else $error("UART receive input not taken from selected pin.");

  property p_in_reset_ones;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (cfg_r[0] == 16'h3f3f && cfg_r[1] == 16'h3f3f && cfg_r[2] == 16'h003f);
  endproperty
  a_in_reset_ones: assert property (p_in_reset_ones) else $error("Input selectors not all ones after reset.");

  property p_rsvd_zero;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite) |-> (prdata[31:14] == 18'h0 && prdata[7:6] == 2'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("Unimplemented bits read as nonzero.");

  property p_ss_low_only;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && acc_idx == 3'h2 && pstrb[0]) |=> (cfg_r[2][15:6] == 10'h0 && cfg_r[2][5:0] == $past(pwdata[5:0]));
  endproperty
  a_ss_low_only: assert property (p_ss_low_only) else $error("Slave select selector width wrong.");

  property p_out_route;
    @(posedge pclk) disable iff (!presetn)
    (cfg_r[3][5:0] != 6'h0) |-> (pin_out_en[0] && pin_out[0] == func_level[cfg_r[3][5:0]]);
  endproperty
  a_out_route: assert property (p_out_route) else $error("Pin 0 not driven by selected function.");

  property p_out_reset_zero;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (cfg_r[3] == 16'h0 && cfg_r[4] == 16'h0 && cfg_r[5] == 16'h0 && pin_out_en == 6'h0);
  endproperty
  a_out_reset_zero: assert property (p_out_reset_zero) else $error("Output selectors not zero after reset.");

  property p_out_pair;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && acc_idx == 3'h4 && pstrb[1:0] == 2'b11)
      |=> (sel_bus.out_func_sel[2] == $past(pwdata[5:0]) && sel_bus.out_func_sel[3] == $past(pwdata[13:8]));
  endproperty
  a_out_pair: assert property (p_out_pair) else $error("Pin pair fields swapped or lost.");

  property p_pin5_absent;
    @(posedge pclk) disable iff (!presetn)
    SMALL_PACKAGE |-> (cfg_r[5][13:8] == 6'h0 && !pin_out_en[5]);
  endproperty
  a_pin5_absent: assert property (p_pin5_absent) else $error("Pin 5 selector present on small package.");

  property p_cts_field;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && acc_idx == 3'h0 && pstrb[1]) |=> (uart4_cts == pin_level[$past(pwdata[13:8])])
      ##1 ($past(wr_fire) || uart4_cts == pin_level[$past(pwdata[13:8], 2)]);
  endproperty
  a_cts_field: assert property (p_cts_field) else $error("Clear-to-send selector not in high field.");

  property p_spi_fields;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && acc_idx == 3'h1 && pstrb[1:0] == 2'b11)
      |=> (spi3_clk == pin_level[$past(pwdata[13:8])] && spi3_din == pin_level[$past(pwdata[5:0])]);
  endproperty
  a_spi_fields: assert property (p_spi_fields) else $error("SPI clock and data fields misplaced.");

  property p_route_next;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && acc_idx == 3'h0 && pstrb[0]) |=> (sel_bus.uart4_rx_pin_sel == $past(pwdata[5:0]));
  endproperty
  a_route_next: assert property (p_route_next) else $error("Routing did not follow the write next cycle.");

endmodule : remappable_pin_select

//--- tb_top.sv
// Self-checking testbench for the remappable pin select block, both package variants.
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk;
  logic presetn;
  logic [1:0] psel_v;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  wire [31:0] rd_v [2];
  wire [1:0] rdy_v;
  wire [1:0] err_v;
  logic [63:0] pin_level;
  logic [63:0] func_level;
  wire [4:0] per_v [2];
  wire [5:0] po_v [2];
  wire [5:0] oe_v [2];
  logic [15:0] m [2][6];
  logic [31:0] seed;
  int failures;
  int checked;

  // Instance 1 is the small package, so the pin 5 selector is absent there.
  for (genvar g = 0; g < 2; g++) begin : g_dut
    remappable_pin_select #(.SMALL_PACKAGE(g == 1)) dut_u (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel_v[g]),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(rd_v[g]),
      .pready(rdy_v[g]),
      .pslverr(err_v[g]),
      .pin_level(pin_level),
      .pin_out(po_v[g]),
      .pin_out_en(oe_v[g]),
      .func_level(func_level),
      .uart4_rx(per_v[g][0]),
      .uart4_cts(per_v[g][1]),
      .spi3_clk(per_v[g][2]),
      .spi3_din(per_v[g][3]),
      .spi3_ss(per_v[g][4])
    );
  end

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD reg at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD pins at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_pin

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input int g, input logic wr, input logic [11:0] a, input logic [31:0] wd,
    input logic [3:0] st, output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel_v <= g[0] ? 2'b10 : 2'b01;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rdy_v[g] !== 1'b1 && n < 20);
    if (rdy_v[g] !== 1'b1) begin
      failures++;
      print_verdict();
    end
    rd = rd_v[g];
    err = err_v[g];
    psel_v <= 2'b00;
    penable <= 1'b0;
  endtask : apb

  // Implemented bits: two 6-bit fields, one field for slave select and small-package pin 4/5.
  function automatic logic [15:0] impl_mask(input int g, input int i);
    if (i == 2 || (g == 1 && i == 5)) begin
      return 16'h003f;
    end
    return 16'h3f3f;
  endfunction : impl_mask

  function automatic logic [16:0] exp_pins(input int g);
    logic [5:0] s;
    logic [5:0] po;
    logic [5:0] oe;
    for (int p = 0; p < 6; p++) begin
      s = (p % 2 == 1) ? m[g][3 + p / 2][13:8] : m[g][3 + p / 2][5:0];
      oe[p] = (s != 6'h00);
      po[p] = (s != 6'h00) ? func_level[s] : 1'b0;
    end
    return {pin_level[m[g][2][5:0]], pin_level[m[g][1][5:0]], pin_level[m[g][1][13:8]],
      pin_level[m[g][0][13:8]], pin_level[m[g][0][5:0]], po, oe};
  endfunction : exp_pins

  // First look lands in the cycle right after the write edge.
  task automatic check_route();
    for (int k = 0; k < 2; k++) begin
      @(negedge pclk);
      for (int g = 0; g < 2; g++) begin
        chk_pin({per_v[g], po_v[g], oe_v[g]}, exp_pins(g));
      end
      @(posedge pclk);
      pin_level <= {rnd(), rnd()};
      func_level <= {rnd(), rnd()};
    end
  endtask : check_route

  task automatic read_all();
    logic [31:0] rd;
    logic err;
    for (int g = 0; g < 2; g++) begin
      for (int i = 0; i < 6; i++) begin
        apb(g, 1'b0, 12'(i * 4), 32'h0, 4'h0, rd, err);
        chk_reg(rd, {16'h0000, m[g][i]});
      end
    end
  endtask : read_all

  task automatic reset_model();
    for (int g = 0; g < 2; g++) begin
      m[g] = '{16'h3f3f, 16'h3f3f, 16'h003f, 16'h0000, 16'h0000, 16'h0000};
    end
  endtask : reset_model

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] rd;
    logic [31:0] wd;
    logic [15:0] bm;
    logic err;
    int i;
    seed = 32'h9c5ec896;
    presetn = 1'b0;
    psel_v = 2'b00;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    pin_level = 64'h0;
    func_level = 64'h0;
    failures = 0;
    checked = 0;
    for (int r = 0; r < 2; r++) begin
      reset_model();
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      read_all();
      check_route();
      for (int g = 0; g < 2; g++) begin
        apb(g, 1'b1, 12'h018, rnd(), 4'hf, rd, err);
        chk_reg({31'h0, err}, 32'h1);
        apb(g, 1'b0, 12'hffc, 32'h0, 4'hf, rd, err);
        chk_reg(rd, 32'h0);
      end
      for (int n = 0; n < 40; n++) begin
        i = rnd() % 6;
        wd = rnd();
        for (int g = 0; g < 2; g++) begin
          apb(g, 1'b1, 12'(i * 4), wd, wd[19:16], rd, err);
          bm = {{8{wd[17]}}, {8{wd[16]}}} & impl_mask(g, i);
          m[g][i] = (m[g][i] & ~bm) | (wd[15:0] & bm);
          chk_reg({31'h0, err}, 32'h0);
        end
        check_route();
      end
      read_all();
      @(posedge pclk);
      presetn <= 1'b0;
    end
    print_verdict();
  end
endmodule : tb_top
